// *** logic/rcoc_ctrl.v ***
`timescale 1ns/1ns
`include "rcoc_regs.vh"

module rcoc_ctrl (
	// Clock and reset
	input wire core_clk,
	input wire rst,
	// APB slave
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [7:0] paddr,
	input wire [31:0] pwdata,
	input wire [3:0] pstrb,
	output reg [31:0] prdata,
	output wire pready,
	output wire pslverr,
	// Per-port clock sources, bit n belongs to port n
	input wire [1:0] serialRecoveredClock,
	input wire [1:0] copperRecoveredClock,
	input wire [1:0] copper_transmit_clock,
	// Per-port link state
	input wire [1:0] linkUp,
	input wire [1:0] linkStable,
	input wire [1:0] master1000,
	input wire [1:0] tenBase,
	input wire [1:0] eeeMode,
	input wire [1:0] lpIdleRx,
	// External squelch pin
	input wire squelchIn,
	// Recovered clock output and its frequency request
	output reg recovered_clock_one_output,
	output reg [2:0] outputFreqSelect,
	output reg outputFreqValid
);

// ==========================================================
// Address decode
function addrHit;
	input [7:0] addr;
	input [7:0] index;
	begin
		addrHit = (addr == {index[5:0], 2'b00});
	end
endfunction

wire hitCtrl;
wire hitStat;
wire mapped;
wire setupPhase;
wire accessPhase;

assign hitCtrl = addrHit(paddr, `RCOC_CTRL_IDX);
assign hitStat = addrHit(paddr, `RCOC_STAT_IDX);
assign mapped = hitCtrl | hitStat;
assign setupPhase = psel & ~penable;
assign accessPhase = psel & penable;

// Zero wait states; unmapped addresses answer with an error
assign pready = 1'b1;
assign pslverr = accessPhase & ~mapped;

// ==========================================================
// Control register
reg [15:0] ctrlReg;
reg [15:0] next_ctrlReg;
reg [15:0] laneMask;

// Byte lanes 0 and 1 carry the register; reserved bits stay zero
always @* begin
	laneMask = {{8{pstrb[1]}}, {8{pstrb[0]}}} & `RCOC_CTRL_WMASK;
	next_ctrlReg = (ctrlReg & ~laneMask) | (pwdata[15:0] & laneMask);
end

// Write takes effect at the access edge
always @(posedge core_clk) begin
	if (rst) begin
		ctrlReg <= `RCOC_CTRL_RESET;
	end else if (accessPhase & pwrite & hitCtrl) begin
		ctrlReg <= next_ctrlReg;
	end
end

// ==========================================================
// Field extraction
wire clockEnable;
wire [3:0] portSelect;
wire [2:0] freqSelect;
wire [1:0] squelchMode;
wire [2:0] typeSelect;

assign clockEnable = ctrlReg[`RCOC_EN_BIT];
assign portSelect = ctrlReg[`RCOC_PORT_HI:`RCOC_PORT_LO];
assign freqSelect = ctrlReg[`RCOC_FREQ_HI:`RCOC_FREQ_LO];
assign squelchMode = ctrlReg[`RCOC_SQ_HI:`RCOC_SQ_LO];
assign typeSelect = ctrlReg[`RCOC_TYPE_HI:`RCOC_TYPE_LO];

// ==========================================================
// Source port choice
reg portLegal;
reg portIndex;

// Reserved port codes are flagged illegal and fall back to the index of port 0
always @* begin
	case (portSelect)
		`RCOC_PORT_ZERO: begin
			portLegal = 1'b1;
			portIndex = 1'b0;
		end
		`RCOC_PORT_ONE: begin
			portLegal = 1'b1;
			portIndex = 1'b1;
		end
		default: begin
			portLegal = 1'b0;
			portIndex = 1'b0;
		end
	endcase
end

// ==========================================================
// Clock type choice for the selected port
reg typeLegal;
reg sourceClock;

always @* begin
	case (typeSelect)
		`RCOC_TYPE_SERIAL: begin
			typeLegal = 1'b1;
			sourceClock = serialRecoveredClock[portIndex];
		end
		`RCOC_TYPE_CU_RX: begin
			typeLegal = 1'b1;
			sourceClock = copperRecoveredClock[portIndex];
		end
		`RCOC_TYPE_CU_TX: begin
			typeLegal = 1'b1;
			sourceClock = copper_transmit_clock[portIndex];
		end
		default: begin
			typeLegal = 1'b0;
			sourceClock = 1'b0;
		end
	endcase
end

// ==========================================================
// Output frequency choice
reg freqLegal;

always @* begin
	case (freqSelect)
		`RCOC_FREQ_25: begin
			freqLegal = 1'b1;
		end
		`RCOC_FREQ_125: begin
			freqLegal = 1'b1;
		end
		`RCOC_FREQ_31P25: begin
			freqLegal = 1'b1;
		end
		default: begin
			freqLegal = 1'b0;
		end
	endcase
end

// ==========================================================
// Squelch decision on the link state of the chosen port
wire clockAllowed;

rcoc_squelch squelchUnit (
	.squelchMode(squelchMode),
	.linkUp(linkUp[portIndex]),
	.linkStable(linkStable[portIndex]),
	.master1000(master1000[portIndex]),
	.tenBase(tenBase[portIndex]),
	.eeeMode(eeeMode[portIndex]),
	.lpIdleRx(lpIdleRx[portIndex]),
	.clockAllowed(clockAllowed)
);

// ==========================================================
// Output gate
wire sourceLegal;
wire gateOpen;

assign sourceLegal = portLegal & typeLegal & freqLegal;

// Pin squelch overrides enable and squelch mode alike
assign gateOpen = clockEnable & sourceLegal & clockAllowed &
	~squelchIn;

// Output held low whenever the gate is shut
always @(posedge core_clk) begin
	if (rst) begin
		recovered_clock_one_output <= 1'b0;
	end else begin
		recovered_clock_one_output <= gateOpen & sourceClock;
	end
end

// Frequency request to the output divider
always @(posedge core_clk) begin
	if (rst) begin
		outputFreqSelect <= `RCOC_FREQ_25;
		outputFreqValid <= 1'b0;
	end else begin
		outputFreqSelect <= freqSelect;
		outputFreqValid <= freqLegal & clockEnable;
	end
end

// ==========================================================
// Status word
wire [15:0] statusWord;

assign statusWord = {11'h000,
	clockAllowed,
	sourceLegal,
	linkUp[portIndex],
	squelchIn,
	gateOpen};

// ==========================================================
// Read data, captured in the setup cycle
reg [31:0] readValue;

always @* begin
	if (hitCtrl) begin
		readValue = {16'h0000, ctrlReg};
	end else if (hitStat) begin
		readValue = {16'h0000, statusWord};
	end else begin
		readValue = 32'h00000000;
	end
end

always @(posedge core_clk) begin
	if (rst) begin
		prdata <= 32'h00000000;
	end else if (setupPhase & ~pwrite) begin
		prdata <= readValue;
	end
end

endmodule

// *** logic/rcoc_regs.vh ***
`ifndef RCOC_REGS_VH
`define RCOC_REGS_VH

// ==========================================================
// Register indices (byte address is four times the index)
`define RCOC_CTRL_IDX 8'h17
`define RCOC_STAT_IDX 8'h1F

// ==========================================================
// Control register field positions
`define RCOC_EN_BIT 15
`define RCOC_PORT_HI 14
`define RCOC_PORT_LO 11
`define RCOC_FREQ_HI 10
`define RCOC_FREQ_LO 8
`define RCOC_SQ_HI 5
`define RCOC_SQ_LO 4
`define RCOC_TYPE_HI 2
`define RCOC_TYPE_LO 0

// Reset value and mask of writable bits
`define RCOC_CTRL_RESET 16'h0000
`define RCOC_CTRL_WMASK 16'hFF37

// ==========================================================
// Source port codes
`define RCOC_PORT_ZERO 4'h0
`define RCOC_PORT_ONE 4'h1

// Output frequency codes
`define RCOC_FREQ_25 3'h0
`define RCOC_FREQ_125 3'h1
`define RCOC_FREQ_31P25 3'h2

// Squelch modes
`define RCOC_SQ_FULL 2'h0
`define RCOC_SQ_RELAXED 2'h1
`define RCOC_SQ_LINKDOWN 2'h2
`define RCOC_SQ_OFF 2'h3

// Clock type codes
`define RCOC_TYPE_SERIAL 3'h0
`define RCOC_TYPE_CU_RX 3'h1
`define RCOC_TYPE_CU_TX 3'h2

// ==========================================================
// Status register bit positions
`define RCOC_STAT_GATE 0
`define RCOC_STAT_EXTSQ 1
`define RCOC_STAT_LINK 2
`define RCOC_STAT_LEGAL 3
`define RCOC_STAT_ALLOW 4

`endif

// *** logic/rcoc_squelch.v ***
`timescale 1ns/1ns
`include "rcoc_regs.vh"

// Decides from the link state of the chosen port whether the
// recovered clock may pass under the selected squelch mode.
module rcoc_squelch (
	// Squelch mode
	input wire [1:0] squelchMode,
	// Link state of the selected port
	input wire linkUp,
	input wire linkStable,
	input wire master1000,
	input wire tenBase,
	input wire eeeMode,
	input wire lpIdleRx,
	// Decision
	output reg clockAllowed
);

// ==========================================================
// Squelch decision
reg linkGood;

always @* begin
	linkGood = linkUp & linkStable;
	case (squelchMode)
		`RCOC_SQ_FULL: begin
			// Down, unstable, master, 10BASE-T or EEE all squelch
			clockAllowed = linkGood & ~master1000 & ~tenBase &
				~eeeMode;
		end
		`RCOC_SQ_RELAXED: begin
			// Master and 10BASE-T pass; EEE only with LP idle
			clockAllowed = linkGood & (~eeeMode | lpIdleRx);
		end
		`RCOC_SQ_LINKDOWN: begin
			clockAllowed = linkUp;
		end
		`RCOC_SQ_OFF: begin
			clockAllowed = 1'b1;
		end
		default: begin
			clockAllowed = 1'b0;
		end
	endcase
end

endmodule

// *** sim/rcoc_chk.sv ***
`timescale 1ns/1ns
// ====================
// Port checker
module rcoc_chk (
	// Clock and reset
	input wire core_clk,
	input wire rst,
	// APB
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [7:0] paddr,
	input wire [31:0] pwdata,
	input wire [31:0] prdata,
	input wire pready,
	input wire pslverr,
	// Clock path
	input wire squelchIn,
	input wire recovered_clock_one_output,
	input wire [2:0] outputFreqSelect,
	input wire outputFreqValid
);
	reg [15:0] ctl;
	wire acc = psel && penable;
	wire ok = ctl[15] && ctl[14:12] == 3'h0 && ctl[2:0] < 3'h3;
	wire bad = paddr != 8'h5C && paddr != 8'h7C;
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	// Shadow of the control register, full-word writes
	always @(posedge core_clk) begin
		if (rst)
			ctl <= 16'h0000;
		else if (acc && pwrite && paddr == 8'h5C)
			ctl <= pwdata[15:0] & 16'hFF37;
	end
	sequence rd_ctl;
		psel && !penable && !pwrite && paddr == 8'h5C ##1 acc;
	endsequence
	// Output one edge after enable, legal codes and a low pin only; the squelch mode decision is not checked
	gate_open_a: assert property (
		recovered_clock_one_output |-> $past(ok) &&
		$past(ctl[10:8]) < 3'h3 && !$past(squelchIn))
		else $error("clock out while gate closed");
	ext_squelch_a: assert property (squelchIn |=>
		!recovered_clock_one_output) else $error("squelch pin ignored");
	freq_copy_a: assert property (outputFreqSelect == $past(ctl[10:8]))
		else $error("frequency code wrong");
	freq_valid_a: assert property (outputFreqValid ==
		($past(ctl[15]) && $past(ctl[10:8]) < 3'h3)) else $error("freq valid");
	ready_now_a: assert property (acc |-> pready) else $error("no ready");
	bad_addr_a: assert property (acc && bad |-> pslverr &&
		(pwrite || prdata == 32'h0)) else $error("unmapped access");
	good_addr_a: assert property (acc && !bad |-> !pslverr)
		else $error("error on mapped address");
	read_back_a: assert property (rd_ctl |->
		prdata == {16'h0000, $past(ctl)}) else $error("read data wrong");
endmodule
bind rcoc_ctrl rcoc_chk rcoc_chk_i (.core_clk, .rst, .psel, .penable,
	.pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .squelchIn,
	.recovered_clock_one_output, .outputFreqSelect, .outputFreqValid);

// *** sim/rcoc_sink.sv ***
`timescale 1ns/1ns
// ====================
// Clock consumer holding the squelch pin
module rcoc_sink (
	// Clock
	input wire core_clk,
	// Squelch request and clock in
	input wire holdReq,
	input wire clkIn,
	output wire squelchIn,
	output reg [15:0] edgeCount = 16'h0000
);
	reg lastIn = 1'b0;
	// Pin high while a hold is requested
	assign squelchIn = holdReq;
	// Counts rising edges of the clock
	always @(posedge core_clk) begin
		lastIn <= clkIn;
		if (clkIn && !lastIn)
			edgeCount <= edgeCount + 16'h0001;
	end
endmodule

// *** sim/recovered_clock_output_ctrl_tb.sv ***
`timescale 1ns/1ns
module recovered_clock_output_ctrl_tb;
	logic core_clk = 0;
	logic rst = 1;
	logic psel = 0;
	logic penable = 0;
	logic pwrite = 0;
	logic hold = 0;
	logic err;
	logic [7:0] paddr = 0;
	logic [31:0] pwdata = 0;
	logic [31:0] prdata;
	logic [31:0] rd;
	logic pready, pslverr, outClk, fValid, sqIn;
	logic [2:0] fSel;
	logic [1:0] ser = 0, cu = 0, tx = 0, up = 0, st = 0;
	logic [1:0] m = 0, tb = 0, ee = 0, lp = 0;
	logic [15:0] edges;
	integer seed = 3042, bad_count = 0, total_checks = 0, i, c, v, n0;
	rcoc_ctrl rcoc_ctrl_i (.core_clk, .rst, .psel, .penable, .pwrite,
		.paddr, .pwdata, .pstrb(4'hF), .prdata, .pready, .pslverr,
		.serialRecoveredClock(ser), .copperRecoveredClock(cu),
		.copper_transmit_clock(tx), .linkUp(up), .linkStable(st),
		.master1000(m), .tenBase(tb), .eeeMode(ee), .lpIdleRx(lp),
		.squelchIn(sqIn), .recovered_clock_one_output(outClk),
		.outputFreqSelect(fSel), .outputFreqValid(fValid));
	rcoc_sink rcoc_sink_i (.core_clk, .holdReq(hold), .clkIn(outClk),
		.squelchIn(sqIn), .edgeCount(edges));
	// Clock
	initial forever #25 core_clk = ~core_clk;
	// Expected output level from control word and link state
	function automatic logic expOut(input integer c);
		integer p;
		logic s;
		p = c[14:11] < 2 ? c[14:11] : 0;
		case (c[5:4])
			0: s = up[p] & st[p] & ~m[p] & ~tb[p] & ~ee[p];
			1: s = up[p] & st[p] & (~ee[p] | lp[p]);
			2: s = up[p];
			default: s = 1;
		endcase
		s = s & (c[1] ? tx[p] : c[0] ? cu[p] : ser[p]);
		return c[15] && c[14:11] < 2 && c[10:8] < 3 && c[2:0] < 3 && !hold && s;
	endfunction
	task chk(input string n, input logic [31:0] s, e);
		total_checks++;
		if (s !== e) begin
			bad_count++;
			$display("wrong value %s expected %h seen %h", n, e, s);
		end
	endtask
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		do @(posedge core_clk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task print_verdict;
		if (bad_count == 0 && total_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// Main sequence
	initial begin
		repeat (3) @(posedge core_clk);
		rst <= 1'b0;
		apb(0, 8'h5C, 0);
		chk("ctrl reset", rd, 0);
		apb(1, 8'h5C, 32'hFFFFFFFF);
		apb(0, 8'h5C, 0);
		chk("ctrl reserved", rd, 32'h0000FF37);
		apb(0, 8'h40, 0);
		chk("unmapped", {rd[30:0], err}, 1);
		for (i = 0; i < 120; i++) begin
			v = $random(seed);
			c = v[28] ? v[15:0] : (v & 32'h8B33) | 32'h8000;
			v = $random(seed);
			up <= v[1:0] | v[3:2];
			st <= v[5:4] | v[7:6];
			m <= v[9:8] & v[11:10];
			tb <= v[13:12] & v[15:14];
			ee <= v[17:16] & v[19:18];
			lp <= v[21:20];
			ser <= v[23:22];
			cu <= v[25:24];
			tx <= v[27:26];
			hold <= v[31:29] == 0;
			apb(1, 8'h5C, c);
			repeat (4) @(posedge core_clk);
			chk("clock out", outClk, expOut(c));
			chk("freq code", fSel, c[10:8]);
			chk("freq valid", fValid, c[15] && c[10:8] < 3);
			apb(0, 8'h5C, 0);
			chk("ctrl read", rd, c & 32'hFF37);
		end
		// Squelch off: each source pulse reaches the consumer, pin blocks
		ser <= 2'b00;
		hold <= 1'b0;
		apb(1, 8'h5C, 32'h00008030);
		for (c = 0; c < 2; c++) begin
			hold <= c[0];
			repeat (4) @(posedge core_clk);
			n0 = edges;
			for (i = 0; i < 8; i++) begin
				ser[0] <= 1'b1;
				repeat (2) @(posedge core_clk);
				ser[0] <= 1'b0;
				repeat (2) @(posedge core_clk);
			end
			repeat (4) @(posedge core_clk);
			chk("edge count", edges - n0, c ? 0 : 8);
		end
		// Reset in mid-run clears the register and the outputs
		rst <= 1'b1;
		repeat (3) @(posedge core_clk);
		rst <= 1'b0;
		@(posedge core_clk);
		chk("out after reset", {outClk, fValid, fSel}, 0);
		apb(0, 8'h5C, 0);
		chk("ctrl after reset", rd, 0);
		print_verdict;
	end
	// Watchdog
	initial begin
		#200000;
		bad_count++;
		print_verdict;
	end
endmodule
